// ===== fp_control_status_consts.vh
// Constants for the floating-point control and status register block.
// Notes on behaviour
// RULE_01 - Bits 59:58 pick dynamic rounding: 00 chop, 01 minus, 10 nearest, 11 plus.
// RULE_02 - Bit 63 always equals the OR of all exception flags.
// RULE_03 - Inexact mask bit 62 set: write result, suppress inexact trap.
// RULE_04 - Underflow: 61 clear traps; 61 set 60 clear traps; both set writes +0.0.
// RULE_05 - Bit 57 sets on integer or float-to-integer overflow of destination.
// RULE_06 - Bit 56 sets when a float result is inexact.
// RULE_07 - Bit 55 sets when a float result underflows the exponent range.
// RULE_08 - Bit 54 sets when a float result overflows the exponent range.
// RULE_09 - Bit 53 sets on a floating-point divide by zero.
// RULE_10 - Bit 52 sets when an operand of a float operation is illegal.
// RULE_11 - Overflow mask bit 51 set: standard result, trap suppressed.
// RULE_12 - Divide-by-zero mask bit 50 set: standard result, trap suppressed.
// RULE_13 - Invalid mask bit 49 set: suppress trap only when hardware can make result.
// RULE_14 - Bit 48 set: denormal operands read as zero with the same sign.
// RULE_15 - Bits 47:0 reserved; bit 47 denormal trap control has no function.
// RULE_16 - Exception with its mask clear records the flag and raises a trap.
`ifndef FP_CONTROL_STATUS_CONSTS_VH
`define FP_CONTROL_STATUS_CONSTS_VH
`define ADDR_CSR_LO 12'h000
`define ADDR_CSR_HI 12'h004
`define ADDR_IRQ_STATUS 12'h008
`define ADDR_IRQ_MASK 12'h00c
`define BIT_SUMMARY 63
`define BIT_INEXACT_MASK 62
`define BIT_UNDERFLOW_MASK 61
`define BIT_UNDERFLOW_ZERO 60
`define RND_HI 59
`define RND_LO 58
`define BIT_FLAG_TOP 57
`define BIT_FLAG_BOT 52
`define BIT_OVF_MASK 51
`define BIT_DZE_MASK 50
`define BIT_INV_MASK 49
`define BIT_DENORM_FLUSH 48
`define HI_KEEP_MASK 32'hffff0000
`define CSR_RESET 64'h0000000000000000
`define IRQ_BITS 2
`define IRQ_TRAP 0
`define IRQ_FLAG 1
`define ONE32 32'h00000001
`endif

// ===== fp_control_status_reg.v
// Floating-point control and status register with APB access and trap decision.
`timescale 1ns/10ps
`default_nettype none
`include "fp_control_status_consts.vh"
module fp_control_status_reg (
   input wire mclk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire evValid,
   input wire evIntOverflow,
   input wire evInexact,
   input wire evUnderflow,
   input wire evOverflow,
   input wire evDivZero,
   input wire evInvalid,
   input wire evInvalidResultOk,
   output reg trapTaken,
   output reg writeTrueZero,
   output reg [1:0] roundingSelect,
   output reg denormOperandFlush,
   output wire irq
);
   reg [63:0] csr;
   reg [1:0] irqStatus;
   reg [1:0] irqMask;
   reg [63:0] next_csr;
   reg [1:0] next_irqStatus;
   reg [5:0] evFlags;
   reg nextTrap;
   reg nextZero;
   wire apbWrite;
   wire apbRead;
   wire addrOk;

   // Register address check, used for both the write enable and the error answer.
   function isMapped;
      input [11:0] a;
      begin
         isMapped = (a == `ADDR_CSR_LO) || (a == `ADDR_CSR_HI) ||
            (a == `ADDR_IRQ_STATUS) || (a == `ADDR_IRQ_MASK);
      end
   endfunction

   assign pready = 1'b1;
   assign addrOk = isMapped(paddr);
   assign pslverr = psel & penable & ~addrOk;
   assign apbWrite = psel & penable & pwrite & addrOk;
   assign apbRead = psel & ~penable & ~pwrite;
   assign irq = |(irqStatus & irqMask);

   // Trap decision per event; integer overflow always traps, the others combine with their mask bits.
   always @* begin
      evFlags = {evIntOverflow, evInexact, evUnderflow, evOverflow, evDivZero, evInvalid};
      if (!evValid) begin
         evFlags = 6'h00;
      end
      nextTrap = 1'b0;
      nextZero = 1'b0;
      if (evValid) begin
         if (evInexact && !csr[`BIT_INEXACT_MASK]) begin
            nextTrap = 1'b1; // RULE_03 RULE_16
         end
         if (evUnderflow) begin
            if (csr[`BIT_UNDERFLOW_MASK] && csr[`BIT_UNDERFLOW_ZERO]) begin
               nextZero = 1'b1; // RULE_04
            end else begin
               nextTrap = 1'b1; // RULE_04 RULE_16
            end
         end
         if (evOverflow && !csr[`BIT_OVF_MASK]) begin
            nextTrap = 1'b1; // RULE_11 RULE_16
         end
         if (evDivZero && !csr[`BIT_DZE_MASK]) begin
            nextTrap = 1'b1; // RULE_12 RULE_16
         end
         // Without a hardware-made result the invalid trap cannot be masked.
         if (evInvalid && !(csr[`BIT_INV_MASK] && evInvalidResultOk)) begin
            nextTrap = 1'b1; // RULE_13 RULE_16
         end
         if (evIntOverflow) begin
            nextTrap = 1'b1; // RULE_16
         end
      end
   end

   // Software writes first, then hardware sets, so a same-cycle event wins.
   always @* begin
      next_csr = csr;
      next_irqStatus = irqStatus;
      if (apbWrite && paddr == `ADDR_CSR_HI) begin
         next_csr[63:32] = pwdata;
      end
      if (apbWrite && paddr == `ADDR_IRQ_STATUS) begin
         next_irqStatus = irqStatus & ~pwdata[`IRQ_BITS-1:0];
      end
      // Reserved low word stays zero; bits 47:32, the bit 47 control included, are stored as written.
      next_csr[31:0] = 32'h00000000; // RULE_15
      next_csr[`BIT_FLAG_TOP:`BIT_FLAG_BOT] = next_csr[`BIT_FLAG_TOP:`BIT_FLAG_BOT] |
         evFlags; // RULE_05 RULE_06 RULE_07 RULE_08 RULE_09 RULE_10
      next_csr[`BIT_SUMMARY] = |next_csr[`BIT_FLAG_TOP:`BIT_FLAG_BOT]; // RULE_02
      if (nextTrap) begin
         next_irqStatus[`IRQ_TRAP] = 1'b1;
      end
      if (|evFlags) begin
         next_irqStatus[`IRQ_FLAG] = 1'b1;
      end
   end

   always @(posedge mclk) begin
      if (rst) begin
         csr <= `CSR_RESET;
         irqStatus <= 2'h0;
         irqMask <= 2'h0;
         prdata <= 32'h00000000;
         trapTaken <= 1'b0;
         writeTrueZero <= 1'b0;
         roundingSelect <= 2'h0;
         denormOperandFlush <= 1'b0;
      end else begin
         csr <= next_csr;
         irqStatus <= next_irqStatus;
         if (apbWrite && paddr == `ADDR_IRQ_MASK) begin
            irqMask <= pwdata[`IRQ_BITS-1:0];
         end
         trapTaken <= nextTrap; // RULE_16
         writeTrueZero <= nextZero; // RULE_04
         roundingSelect <= next_csr[`RND_HI:`RND_LO]; // RULE_01
         denormOperandFlush <= next_csr[`BIT_DENORM_FLUSH]; // RULE_14
         if (apbRead) begin
            if (paddr == `ADDR_CSR_LO) begin
               prdata <= csr[31:0];
            end else if (paddr == `ADDR_CSR_HI) begin
               prdata <= csr[63:32];
            end else if (paddr == `ADDR_IRQ_STATUS) begin
               prdata <= {30'h00000000, irqStatus};
            end else if (paddr == `ADDR_IRQ_MASK) begin
               prdata <= {30'h00000000, irqMask};
            end else begin
               prdata <= 32'h00000000;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== fp_control_status_reg_checker.sv
// Assertion checker for the floating-point control and status register block.
`timescale 1ns/10ps
`default_nettype none
module fp_control_status_reg_checker (
   input wire logic mclk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic evValid,
   input wire logic evIntOverflow,
   input wire logic evUnderflow,
   input wire logic trapTaken,
   input wire logic writeTrueZero,
   input wire logic [1:0] roundingSelect,
   input wire logic denormOperandFlush
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence sIov;
      evValid && evIntOverflow;
   endsequence
   chk_iov_traps: assert property (sIov |=> trapTaken)
      else $error("integer overflow gave no trap");
   chk_trap_cause: assert property (trapTaken |-> $past(evValid))
      else $error("trap without an event");
   chk_zero_cause: assert property (writeTrueZero |-> $past(evValid && evUnderflow))
      else $error("true zero without an underflow event");
   chk_idle_quiet: assert property (!evValid |=> !trapTaken && !writeTrueZero)
      else $error("pulse with no event");
   chk_round_hold: assert property (!(psel && penable && pwrite) |=> $stable(roundingSelect))
      else $error("rounding mode moved without a write");
   chk_flush_hold: assert property (!(psel && penable && pwrite) |=> $stable(denormOperandFlush))
      else $error("denormal flush moved without a write");
   chk_bad_addr: assert property (psel && penable && paddr > 12'h00c |-> pslverr)
      else $error("unmapped access not refused");
   chk_ready_now: assert property (psel && penable |-> pready)
      else $error("access phase stretched");
endmodule
bind fp_control_status_reg fp_control_status_reg_checker u_chk (.mclk(mclk), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .evValid(evValid), .evIntOverflow(evIntOverflow),
   .evUnderflow(evUnderflow), .trapTaken(trapTaken), .writeTrueZero(writeTrueZero),
   .roundingSelect(roundingSelect), .denormOperandFlush(denormOperandFlush));
`default_nettype wire

// ===== fp_control_status_reg_test.sv
// Self-checking testbench for the floating-point control and status register block.
`timescale 1ns/10ps
`default_nettype none
module fp_control_status_reg_test;
   logic mclk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, evValid = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [5:0] ev = 6'h0;
   logic okRes = 1'h1;
   logic pready, pslverr, trapTaken, writeTrueZero, denormOperandFlush, irq, err;
   logic [1:0] roundingSelect;
   int error_cnt = 0, num_checks = 0;
   fp_control_status_reg u_fp_control_status_reg (.mclk(mclk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .evValid(evValid), .evIntOverflow(ev[5]),
      .evInexact(ev[4]), .evUnderflow(ev[3]), .evOverflow(ev[2]), .evDivZero(ev[1]),
      .evInvalid(ev[0]), .evInvalidResultOk(okRes), .trapTaken(trapTaken),
      .writeTrueZero(writeTrueZero), .roundingSelect(roundingSelect),
      .denormOperandFlush(denormOperandFlush), .irq(irq));
   initial forever #4 mclk = ~mclk;
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      do @(posedge mclk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      #1;
   endtask
   task automatic evt(input logic [5:0] v, input logic tr, input logic wz);
      @(posedge mclk);
      evValid <= 1'h1;
      ev <= v;
      @(posedge mclk);
      evValid <= 1'h0;
      #1 chk("trap", {31'h0, trapTaken}, {31'h0, tr});
      chk("zero", {31'h0, writeTrueZero}, {31'h0, wz});
   endtask
   task automatic t_regs;
      for (int i = 0; i < 4; i++) begin
         apb(1'h1, 12'h004, 32'h04000000 * i);
         chk("round", {30'h0, roundingSelect}, i);
      end
      apb(1'h1, 12'h004, 32'h7fff0000);
      apb(1'h0, 12'h004, 32'h0);
      chk("high", rd, 32'hffff0000);
      chk("flush", {31'h0, denormOperandFlush}, 32'h1);
      apb(1'h1, 12'h004, 32'h0);
      apb(1'h0, 12'h004, 32'h0);
      chk("cleared", rd, 32'h0);
      apb(1'h0, 12'h000, 32'h0);
      chk("low", rd, 32'h0);
      apb(1'h0, 12'h010, 32'h0);
      chk("refused", {31'h0, err}, 32'h1);
   endtask
   task automatic t_flags;
      for (int i = 0; i < 6; i++) begin
         apb(1'h1, 12'h004, 32'h0);
         evt(6'h1 << i, 1'h1, 1'h0);
         apb(1'h0, 12'h004, 32'h0);
         chk("flag", rd, 32'h80000000 | (32'h1 << (20 + i)));
      end
   endtask
   task automatic t_masks;
      apb(1'h1, 12'h004, 32'h700e0000);
      for (int i = 0; i < 5; i++) evt(6'h1 << i, 1'h0, i == 3);
      okRes <= 1'h0;
      evt(6'h01, 1'h1, 1'h0);
      okRes <= 1'h1;
      apb(1'h1, 12'h004, 32'h20000000);
      evt(6'h08, 1'h1, 1'h0);
   endtask
   task automatic t_irq;
      apb(1'h1, 12'h008, 32'h3);
      apb(1'h1, 12'h00c, 32'h1);
      evt(6'h20, 1'h1, 1'h0);
      @(posedge mclk);
      #1 chk("irq set", {31'h0, irq}, 32'h1);
      apb(1'h1, 12'h008, 32'h1);
      chk("irq clear", {31'h0, irq}, 32'h0);
   endtask
   task automatic close_out;
      $display("errors %0d checks %0d", error_cnt, num_checks);
      if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      rst <= 1'h0;
      t_regs;
      t_flags;
      t_masks;
      t_irq;
      close_out;
   end
   initial begin
      #20000;
      error_cnt++;
      close_out;
   end
endmodule
`default_nettype wire
